// ### bench/op_source.sv
`timescale 1ns/10ps
module op_source (
    input  wire logic            clk_sys,  // system clock
    input  wire logic            rst,      // sync reset, high
    input  wire logic            go,       // bench asks for one operation
    input  wire logic [3:0]      lag,      // idle cycles before start
    input  wire fp_pkg::fp_req_t go_req,   // operands to issue
    output logic                 start,    // start strobe to datapath
    output fp_pkg::fp_req_t      req,      // operand bus, held to done
    input  wire logic            done_r,   // datapath result pulse
    input  wire logic [47:0]     result_r, // datapath result word
    output logic                 fin,      // one-cycle completion flag
    output logic [47:0]          got       // captured result word
);
    import fp_pkg::*;
    logic [3:0] wait_r;  // lag cycles still to run
    logic       armed_r; // request accepted from bench
    logic       pend_r;  // operation in flight
    // issue one operation, slow or prompt, and hold operands to done
    always_ff @(posedge clk_sys) begin
        start <= 1'b0;
        fin <= 1'b0;
        if (rst) begin
            armed_r <= 1'b0;
            pend_r <= 1'b0;
            req <= '0;
            got <= '0;
        end else if (go) begin
            armed_r <= 1'b1;
            wait_r <= lag;
        end else if (armed_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (armed_r) begin
            // operands driven with start and never touched until done
            armed_r <= 1'b0;
            pend_r <= 1'b1;
            start <= 1'b1;
            req <= go_req;
        end else if (pend_r && done_r) begin
            pend_r <= 1'b0;
            fin <= 1'b1;
            got <= result_r;
            // released bus shows garbage so stale operands are not reused
            req <= ~req;
        end
    end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import fp_pkg::*;
    logic        clk_sys = 1'b0;  // 10 MHz clock
    logic        rst = 1'b1;      // sync reset
    logic        go = 1'b0;       // request to partner
    logic [3:0]  lag = 4'h0;      // partner delay
    fp_req_t     go_req = '0;     // operands for partner
    logic        start;           // partner start strobe
    fp_req_t     req;             // partner operand bus
    logic [47:0] result_r;        // result word
    logic        done_r;          // result pulse
    logic        busy_r;          // in flight
    logic        sense_stb = 1'b0; // sense strobe
    logic [1:0]  sense_sel = 2'h0; // fault select
    logic        sense_hit_r;     // sense answer
    logic [2:0]  fault_req_r;     // interrupt requests
    logic [3:0]  addr = 4'h0;     // register address
    logic [31:0] wdata = 32'h0;   // register write data
    logic        wr_stb = 1'b0;   // write strobe
    logic        rd_stb = 1'b0;   // read strobe
    logic [31:0] rdata_r;         // read data
    logic        fin;             // partner done flag
    logic [47:0] got;             // partner captured result
    int          error_cnt = 0;   // mismatches
    int          total_checks = 0; // comparisons

    always #50 clk_sys = ~clk_sys;

    float_add_sub_mul_div_post i_float_add_sub_mul_div_post (
        .clk_sys(clk_sys), .rst(rst), .start(start), .req(req),
        .result_r(result_r), .done_r(done_r), .busy_r(busy_r),
        .sense_stb(sense_stb), .sense_sel(sense_sel),
        .sense_hit_r(sense_hit_r), .fault_req_r(fault_req_r),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata_r(rdata_r));
    op_source i_op_source (
        .clk_sys(clk_sys), .rst(rst), .go(go), .lag(lag),
        .go_req(go_req), .start(start), .req(req), .done_r(done_r),
        .result_r(result_r), .fin(fin), .got(got));

    // single compare for every result kind, widened to a word
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        rd_stb <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(negedge clk_sys);
        chk({16'h0, rdata_r}, {16'h0, e});
    endtask
    task automatic sense(input logic [1:0] s, input logic e);
        @(posedge clk_sys);
        sense_stb <= 1'b1; sense_sel <= s;
        @(posedge clk_sys);
        sense_stb <= 1'b0;
        @(negedge clk_sys);
        chk({47'h0, sense_hit_r}, {47'h0, e});
    endtask
    // operation through the partner, bounded wait on its flag
    task automatic run_core(input op_t op, input logic [47:0] a, m, c, x, e,
                            input logic [3:0] l);
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys);
        go <= 1'b1;
        lag <= l;
        go_req <= '{op, a, m, c, x};
        @(posedge clk_sys);
        go <= 1'b0;
        // faults are sensed only once the result is back
        repeat (300) begin
            @(negedge clk_sys);
            if (busy_r === 1'b1)
                seen = 1'b1;
            if (fin === 1'b1) break;
        end
        chk({47'h0, fin}, 48'h1);
        chk({47'h0, seen}, 48'h1);
        chk({47'h0, busy_r}, 48'h0);
        chk(got, e);
    endtask
    // add, subtract and the zero-divisor divide carry no raw coefficient from the core
    task automatic run_op(input op_t op, input logic [47:0] a, m, e,
                          input logic [3:0] l);
        run_core(op, a, m, 48'h0, 48'h0, e, l);
    endtask

    // register port: reset values, unmapped place, write and read back
    task automatic t_regs();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STAT, 32'h0);
        rd(4'h8, 32'h0);
        wr(4'h8, 32'hffff_ffff);
        wr(OFS_CTRL, 32'h7);
        rd(OFS_CTRL, 32'h7);
    endtask
    // add, subtract and multiply arithmetic, with sign, bias and rounding cases
    task automatic t_arith();
        run_op(OP_ADD, 48'h4008_0000_0000, 48'h4008_0000_0000, 48'h4018_0000_0000, 4'h0);
        run_op(OP_SUB, 48'h4038_0000_0000, 48'h4008_0000_0000, 48'h402e_0000_0000, 4'h5);
        run_op(OP_SUB, 48'h4008_0000_0000, 48'h4038_0000_0000, 48'hbfd1_ffff_ffff, 4'h0);
        run_op(OP_ADD, 48'hbfc7_ffff_ffff, 48'hbfc7_ffff_ffff, 48'hbfb7_ffff_ffff, 4'h2);
        run_op(OP_ADD, 48'h3fe8_0000_0000, 48'h3fe8_0000_0000, 48'h4008_0000_0000, 4'h0);
        run_op(OP_ADD, 48'h4008_0000_0001, 48'h4018_0000_0000, 48'h401c_0000_0001, 4'h0);
        run_op(OP_ADD, 48'h4018_0000_0000, 48'hbff7_ffff_fffe,
               48'h3fef_ffff_fffc, 4'h1);
        run_core(OP_MUL, 48'h4008_0000_0000, 48'h4018_0000_0000,
                 48'h0004_0000_0000, 48'h8000_0000_0000,
                 48'h4008_0000_0002, 4'h0);
    endtask
    // overflow raised, requested, read, then sensed away
    task automatic t_ovf();
        run_op(OP_ADD, 48'h7ff8_0000_0000, 48'h7ff8_0000_0000, 48'h0008_0000_0000, 4'h0);
        chk({45'h0, fault_req_r}, 48'h1);
        rd(OFS_STAT, 32'h1);
        sense(2'h0, 1'b1);
        sense(2'h0, 1'b0);
        chk({45'h0, fault_req_r}, 48'h0);
    endtask
    task automatic t_unf();
        run_op(OP_SUB, 48'h000c_0000_0000, 48'h0008_0000_0000, 48'h7ff8_0000_0000, 4'h3);
        rd(OFS_STAT, 32'h2);
        sense(2'h1, 1'b1);
        sense(2'h1, 1'b0);
    endtask
    // zero divisor, then the unused select, then sense clears it
    task automatic t_div();
        run_op(OP_DIV, 48'h4008_0000_0000, 48'h0, 48'h0, 4'h0);
        // a good divide while the fault is still pending
        run_core(OP_DIV, 48'h4008_0000_0000, 48'h4008_0000_0000,
                 48'h0008_0000_0000, 48'h0004_0000_0000,
                 48'h4008_0000_0001, 4'h0);
        chk({45'h0, fault_req_r}, 48'h4);
        sense(2'h3, 1'b0);
        sense(2'h2, 1'b1);
        rd(OFS_STAT, 32'h0);
    endtask

    // watchdog sized well above the few dozen cycles per operation
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_arith();
        t_ovf();
        t_unf();
        t_div();
        summarize();
    end
endmodule

// ### rtl/float_add_sub_mul_div_post.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
module float_add_sub_mul_div_post (
    input  wire logic             clk_sys,     // 10 MHz clock
    input  wire logic             rst,         // sync reset, high
    input  wire logic             start,       // begin one operation
    input  wire fp_pkg::fp_req_t  req,         // operands, held at start
    output logic [47:0]           result_r,    // packed result word
    output logic                  done_r,      // one-cycle result pulse
    output logic                  busy_r,      // operation in flight
    input  wire logic             sense_stb,   // sense instruction strobe
    input  wire logic [1:0]       sense_sel,   // which fault to sense
    output logic                  sense_hit_r, // sensed fault was set
    output logic [2:0]            fault_req_r, // per-fault interrupt req
    input  wire logic [3:0]       addr,        // register address
    input  wire logic [31:0]      wdata,       // register write data
    input  wire logic             wr_stb,      // register write strobe
    input  wire logic             rd_stb,      // register read strobe
    output logic [31:0]           rdata_r      // read data, next cycle
);
    import fp_pkg::*;

    state_t             state_r;   // sequencer state
    op_t                op_r;      // latched operation
    rnd_t               rnd_r;     // chosen rounding quantity
    logic [47:0]        sh_r;      // upper part of combined shifter
    logic [47:0]        e_r;       // extension register
    logic [47:0]        oth_r;     // unshifted addend
    logic signed [12:0] exp_r;     // true result exponent
    logic [5:0]         cnt_r;     // shift counter
    logic [2:0]         flags_r;   // overflow, underflow, divide
    logic [2:0]         en_r;      // interrupt request enables
    logic [2:0]         set_f;     // faults raised this cycle
    logic [2:0]         clr_f;     // faults sensed this cycle

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // one's complement add with end-around carry
    function automatic logic [47:0] oc_add(input logic [47:0] a,
                                           input logic [47:0] b);
        logic [48:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[47:0] + {{(W-1){1'b0}}, s[W]};
    endfunction

    // biased exponent back to true exponent
    function automatic logic signed [12:0] true_exp(input logic [47:0] w);
        logic [10:0]        b;
        logic signed [12:0] bx;
        b  = w[SIGN] ? ~w[EXP_HI:EXP_LO] : w[EXP_HI:EXP_LO];
        bx = $signed({2'b00, b});
        // upper half loses 2000, lower half 1777
        return (bx >= BIAS_POS) ? bx - BIAS_POS : bx - BIAS_NEG;
    endfunction

    // fraction with sign spread over the upper bits
    function automatic logic [47:0] coef(input logic [47:0] w);
        return {{XW{w[SIGN]}}, w[CW-1:0]};
    endfunction

    // sign pair to rounding: 01 add, 10 subtract, else none
    function automatic rnd_t rnd_pick(input logic a, input logic e);
        case ({a, e})
            2'b01:   return RND_ADD;
            2'b10:   return RND_SUB;
            default: return RND_NONE;
        endcase
    endfunction

    // operand decode, combinational
    logic signed [12:0] ta, tb, dexp;
    logic [47:0]        ca, cb_m;
    logic [35:0]        dmag;
    logic [47:0]        rmag;
    logic               div_bad, half_up;
    always_comb begin
        ta   = true_exp(req.aq);
        tb   = true_exp(req.mem);
        ca   = coef(req.aq);
        // subtract works on the complemented storage coefficient
        cb_m = (req.op == OP_SUB) ? ~coef(req.mem) : coef(req.mem);
        dexp = ta - tb;
        dmag = req.mem[SIGN] ? ~req.mem[CW-1:0] : req.mem[CW-1:0];
        // zero or unnormalized divisor cannot give a fraction
        div_bad = ~dmag[NORM_BIT];
        rmag = req.core_ext[SIGN] ? ~req.core_ext : req.core_ext;
        // twice the residue against the divisor means ratio vs half
        half_up = ({rmag, 1'b0} >= {13'h0000, dmag});
    end

    // pack path: overflow checks and biased exponent
    logic signed [12:0] bexp;
    logic [35:0]        mag;
    logic               res_zero, ovf, unf;
    logic [47:0]        packed_w;
    always_comb begin
        mag      = sh_r[SIGN] ? ~sh_r[CW-1:0] : sh_r[CW-1:0];
        res_zero = (mag == 36'h000000000);
        ovf      = !res_zero && (exp_r > EXP_MAX);
        unf      = !res_zero && (exp_r < -EXP_MAX);
        // a signed integer has no minus zero, so zero takes 2000
        bexp = (exp_r >= 13'sh0000) ? exp_r + BIAS_POS
                                   : exp_r + BIAS_NEG;
        packed_w = {1'b0, bexp[10:0], mag};
        if (sh_r[SIGN])
            packed_w = ~packed_w;
        if (res_zero)
            packed_w = ZERO48;
    end

    // sequencer and datapath
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= ST_IDLE;
            op_r    <= OP_ADD;
            rnd_r   <= RND_NONE;
            sh_r    <= ZERO48;
            e_r     <= ZERO48;
            oth_r   <= ZERO48;
            exp_r   <= 13'sh0000;
            cnt_r   <= 6'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        op_r  <= req.op;
                        e_r   <= ZERO48;
                        rnd_r <= RND_NONE;
                        cnt_r <= 6'h00;
                        if (req.op == OP_ADD || req.op == OP_SUB) begin
                            state_r <= ST_ALIGN;
                            if (dexp < 13'sh0000) begin
                                // accumulator has the smaller exponent
                                sh_r  <= ca;
                                oth_r <= cb_m;
                                // negative coefficient extends with ones
                                e_r   <= {W{ca[SIGN]}};
                                exp_r <= tb;
                                cnt_r <= (-dexp > 13'sh003f) ? MAX_SHIFT
                                         : 6'((-dexp));
                            end else begin
                                // storage operand is the one shifted
                                sh_r  <= cb_m;
                                oth_r <= ca;
                                e_r   <= {W{cb_m[SIGN]}};
                                exp_r <= ta;
                                cnt_r <= (dexp > 13'sh003f) ? MAX_SHIFT
                                         : 6'(dexp);
                            end
                        end else begin
                            // raw product or quotient enters rounding
                            sh_r    <= req.core_coef;
                            e_r     <= req.core_ext;
                            oth_r   <= ZERO48;
                            state_r <= ST_ROUND;
                            if (req.op == OP_MUL) begin
                                exp_r <= ta + tb;
                                rnd_r <= rnd_pick(req.core_coef[SIGN],
                                                  req.core_ext[SIGN]);
                            end else begin
                                exp_r <= dexp;
                                if (div_bad) begin
                                    // no quotient, packs as a zero word
                                    sh_r    <= ZERO48;
                                    state_r <= ST_PACK;
                                end else if (half_up)
                                    rnd_r <= req.core_coef[SIGN]
                                             ? RND_SUB : RND_ADD;
                            end
                        end
                    end
                end
                ST_ALIGN: begin
                    if (cnt_r != 6'h00) begin
                        // shifter and extension move as one, sign fill
                        sh_r  <= {sh_r[SIGN], sh_r[W-1:1]};
                        e_r   <= {sh_r[0], e_r[W-1:1]};
                        cnt_r <= cnt_r - CNT_ONE;
                    end else begin
                        // bit 23 sampled right after equalization
                        rnd_r   <= rnd_pick(sh_r[UPPER23],
                                            e_r[EXT47]);
                        state_r <= ST_SUM;
                    end
                end
                ST_SUM: begin
                    sh_r    <= oc_add(sh_r, oth_r);
                    state_r <= ST_ROUND;
                end
                ST_ROUND: begin
                    // one at the lowest bit, exponent left alone
                    case (rnd_r)
                        RND_ADD: sh_r <= oc_add(sh_r, ONE48);
                        RND_SUB: sh_r <= oc_add(sh_r, ~ONE48);
                        default: sh_r <= oc_add(sh_r, ZERO48);
                    endcase
                    cnt_r   <= 6'h00;
                    state_r <= ST_NORM;
                end
                ST_NORM: begin
                    // extension never moves here
                    if (sh_r[OVF_BIT] != sh_r[SIGN]) begin
                        sh_r  <= {sh_r[SIGN], sh_r[W-1:1]};
                        exp_r <= exp_r + EXP_ONE;
                    end else if (sh_r[NORM_BIT] == sh_r[SIGN]
                                 && cnt_r < NORM_MAX) begin
                        // zero result stops at the limit
                        sh_r  <= {sh_r[W-2:0], sh_r[SIGN]};
                        exp_r <= exp_r - EXP_ONE;
                        cnt_r <= cnt_r + CNT_ONE;
                    end else begin
                        state_r <= ST_PACK;
                    end
                end
                ST_PACK: begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // result word and completion pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_r <= ZERO48;
            done_r   <= 1'b0;
            busy_r   <= 1'b0;
        end else begin
            done_r <= (state_r == ST_PACK);
            busy_r <= (state_r != ST_IDLE && state_r != ST_PACK)
                      || (state_r == ST_IDLE && start);
            if (state_r == ST_PACK)
                result_r <= packed_w;
        end
    end

    // fault raise and sense clear, raise wins
    always_comb begin
        set_f        = 3'h0;
        set_f[F_OVF] = (state_r == ST_PACK) && ovf;
        set_f[F_UNF] = (state_r == ST_PACK) && unf;
        set_f[F_DIV] = (state_r == ST_IDLE) && start
                       && (req.op == OP_DIV) && div_bad;
        clr_f = 3'h0;
        if (sense_stb && sense_sel <= 2'(F_DIV))
            clr_f[sense_sel] = 1'b1;
    end

    // flags, sense answer and interrupt requests
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_r     <= 3'h0;
            sense_hit_r <= 1'b0;
            fault_req_r <= 3'h0;
        end else begin
            flags_r     <= (flags_r & ~clr_f) | set_f;
            sense_hit_r <= |(flags_r & clr_f);
            // flag raised now requests at once, cleared one drops
            fault_req_r <= ((flags_r & ~clr_f) | set_f) & en_r;
        end
    end

    // register port: enables writable, status readable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_r    <= CTRL_RST;
            rdata_r <= 32'h00000000;
        end else begin
            if (wr_stb && addr == OFS_CTRL)
                en_r <= wdata[2:0];
            rdata_r <= 32'h00000000;
            if (rd_stb && addr == OFS_CTRL)
                rdata_r <= {29'h00000000, en_r};
            else if (rd_stb && addr == OFS_STAT)
                rdata_r <= {28'h0000000, busy_r, flags_r};
        end
    end

    sequence s_round_norm;
        (state_r == ST_ROUND) ##1 (state_r == ST_NORM);
    endsequence

    sequence s_align_out;
        (state_r == ST_ALIGN && cnt_r == 6'h00) ##1 (state_r == ST_SUM);
    endsequence

    // a faulted divide goes straight to packing
    sequence s_div_fault;
        (state_r == ST_IDLE && start && req.op == OP_DIV && div_bad)
        ##1 (state_r == ST_PACK);
    endsequence

    AST_ALIGN_BOUND: assert property (
        $rose(state_r == ST_ALIGN) |-> ##[1:64] (state_r == ST_SUM))
        else $error("equalization ran past 63 shifts");
    AST_ROUND_ADD: assert property (
        (state_r == ST_ALIGN && cnt_r == 6'h00 && !sh_r[UPPER23]
         && e_r[EXT47]) |-> s_align_out ##0 (rnd_r == RND_ADD))
        else $error("add-one rounding not chosen");
    AST_ROUND_SUB: assert property (
        (state_r == ST_ALIGN && cnt_r == 6'h00 && sh_r[UPPER23]
         && !e_r[EXT47]) |=> (rnd_r == RND_SUB))
        else $error("subtract-one rounding not chosen");
    AST_ROUND_EXP: assert property (
        (state_r == ST_SUM) |=> s_round_norm ##0 $stable(exp_r))
        else $error("rounding touched the exponent");
    AST_NORM_EXT: assert property (
        (state_r == ST_NORM) |=> $stable(e_r))
        else $error("normalization moved the extension");
    AST_NORM_RIGHT: assert property (
        (state_r == ST_NORM && sh_r[OVF_BIT] != sh_r[SIGN])
        |=> (exp_r == $past(exp_r) + EXP_ONE)
            && (sh_r[SIGN] == $past(sh_r[SIGN])))
        else $error("right normalize lost exponent step");
    AST_NORMALIZED: assert property (
        (done_r && result_r != ZERO48)
        |-> (result_r[NORM_BIT] != result_r[SIGN]))
        else $error("result coefficient not normalized");
    AST_OVF_FLAG: assert property (
        (state_r == ST_PACK && ovf) |=> flags_r[F_OVF] [*1] ##1 done_r == 1'b0)
        else $error("overflow not flagged");
    AST_DIV_FLAG: assert property (
        (state_r == ST_IDLE && start && req.op == OP_DIV && div_bad)
        |=> flags_r[F_DIV] ##[1:2] (done_r && result_r == ZERO48))
        else $error("divide fault not flagged");
    AST_SENSE_CLR: assert property (
        (sense_stb && sense_sel == 2'(F_UNF) && flags_r[F_UNF]
         && !set_f[F_UNF]) |=> (sense_hit_r && !flags_r[F_UNF]))
        else $error("sense did not report and clear");

    // product rounding from the two sign bits
    AST_ROUND_MUL: assert property (
        (state_r == ST_ROUND && op_r == OP_MUL && !sh_r[SIGN]
         && e_r[SIGN]) |-> (rnd_r == RND_ADD))
        else $error("multiply add-one rounding not chosen");

    // residue at least half the divisor rounds away
    AST_ROUND_DIV: assert property (
        (state_r == ST_IDLE && start && req.op == OP_DIV && !div_bad
         && half_up && !req.core_coef[SIGN]) |=> (rnd_r == RND_ADD))
        else $error("divide rounding not chosen");

    // faulted divide hands back a zero word
    AST_DIV_ZERO: assert property (
        s_div_fault |=> (done_r && result_r == ZERO48))
        else $error("faulted divide result not zero");

    // underflow raised at pack time
    AST_UNF_FLAG: assert property (
        (state_r == ST_PACK && unf) |=> flags_r[F_UNF])
        else $error("underflow not flagged");

    // interrupt requests follow flags and enables
    AST_FAULT_REQ: assert property (
        fault_req_r == (flags_r & $past(en_r)))
        else $error("interrupt request out of step");

    // a sense answer only follows a sense strobe
    AST_SENSE_HIT: assert property (
        sense_hit_r |-> $past(sense_stb))
        else $error("sense answer without strobe");

    // bit leaving the shifter enters the extension
    AST_EXT_ALIGN: assert property (
        (state_r == ST_ALIGN && cnt_r != 6'h00)
        |=> (e_r[EXT47] == $past(sh_r[0])))
        else $error("extension lost a shifted bit");

    // zero true exponent takes the positive bias
    AST_BIAS_ZERO: assert property (
        (state_r == ST_PACK && exp_r == 13'sh0000) |-> (bexp == BIAS_POS))
        else $error("zero exponent not biased as plus");
endmodule

// ### rtl/fp_pkg.sv
package fp_pkg;
    localparam int W        = 48;      // word and accumulator pair width
    localparam int CW       = 36;      // fraction width
    localparam int XW       = 12;      // sign extension above fraction
    localparam int SIGN     = 47;      // coefficient sign bit
    localparam int EXP_HI   = 46;      // exponent field top
    localparam int EXP_LO   = 36;      // exponent field bottom
    localparam int UPPER23  = 47;      // upper accumulator bit 23
    localparam int EXT47    = 47;      // extension bit 47
    localparam int NORM_BIT = 35;      // leading fraction bit
    localparam int OVF_BIT  = 36;      // first bit above fraction
    localparam logic signed [12:0] BIAS_POS = 13'sh400; // 2000 octal
    localparam logic signed [12:0] BIAS_NEG = 13'sh3ff; // 1777 octal
    localparam logic signed [12:0] EXP_MAX  = 13'sh3ff; // 1777 octal
    localparam logic signed [12:0] EXP_ONE  = 13'sh001; // exponent step
    localparam logic [5:0]  MAX_SHIFT = 6'h3f;  // 77 octal shifts
    localparam logic [5:0]  NORM_MAX  = 6'h24;  // left shift limit
    localparam logic [5:0]  CNT_ONE   = 6'h01;  // counter step
    localparam logic [47:0] ONE48     = 48'h000000000001;
    localparam logic [47:0] ZERO48    = 48'h000000000000;
    localparam logic [3:0]  OFS_CTRL  = 4'h0;   // request enables
    localparam logic [3:0]  OFS_STAT  = 4'h4;   // faults and busy
    localparam logic [2:0]  CTRL_RST  = 3'h0;   // enables after reset
    localparam int F_OVF = 0;                   // overflow flag index
    localparam int F_UNF = 1;                   // underflow flag index
    localparam int F_DIV = 2;                   // divide flag index
    typedef enum logic [1:0] {
        OP_ADD = 2'b00, OP_SUB = 2'b01, OP_MUL = 2'b10, OP_DIV = 2'b11
    } op_t;
    typedef enum logic [1:0] {
        RND_NONE = 2'b00, RND_ADD = 2'b01, RND_SUB = 2'b10
    } rnd_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000, ST_ALIGN = 3'b001, ST_SUM  = 3'b010,
        ST_ROUND = 3'b011, ST_NORM  = 3'b100, ST_PACK = 3'b101
    } state_t;
    typedef struct packed {
        op_t         op;        // operation
        logic [47:0] aq;        // accumulator pair word
        logic [47:0] mem;       // storage operand word
        logic [47:0] core_coef; // raw multiply/divide coefficient
        logic [47:0] core_ext;  // extension or divide residue
    } fp_req_t;
endpackage
